// file: design/i2csr_pkg.sv
// package: register map, bit fields, wait tables and types of the start/reservation host
package i2csr_pkg;
	// device register offsets as seen on the host's register port
	localparam logic [2:0] OFS_CONTROL = 3'h0;
	localparam logic [2:0] OFS_STATUS = 3'h1;
	localparam logic [2:0] OFS_FLAG = 3'h2;
	localparam logic [2:0] OFS_CLK_SEL = 3'h3;
	localparam logic [2:0] OFS_CLK_EXT = 3'h4;
	localparam logic [2:0] OFS_SHIFT = 3'h5;
	// control register bits
	localparam int CTL_ENABLE_BIT = 7;
	localparam int CTL_RELEASE_BIT = 6;
	localparam int CTL_STOP_IRQ_BIT = 4;
	localparam int CTL_START_BIT = 1;
	localparam int CTL_STOP_BIT = 0;
	// status register bits
	localparam int STS_MASTER_BIT = 7;
	localparam int STS_START_DET_BIT = 1;
	localparam int STS_STOP_DET_BIT = 0;
	// flag register bits
	localparam int FLG_START_FAIL_BIT = 7;
	localparam int FLG_BUS_BUSY_BIT = 6;
	localparam int FLG_START_CHECK_BIT = 1;
	localparam int FLG_RSV_DISABLE_BIT = 0;
	// clock select / extension bits
	localparam int CLK_SPEED_BIT = 3;
	localparam int CLK_EXT_BIT = 0;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	// bus-free time before an init with start check completes, in link clocks
	localparam int LINK_PERIOD_NS = 125;
	localparam int BUS_FREE_NS = 10000;
	localparam logic [7:0] BUS_FREE_CYC = 8'((BUS_FREE_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
	// wait before reading master status, reservation enabled
	localparam logic [7:0] WAIT_RSV_0000 = 8'h2E;
	localparam logic [7:0] WAIT_RSV_0001 = 8'h56;
	localparam logic [7:0] WAIT_RSV_0010 = 8'hAC;
	localparam logic [7:0] WAIT_RSV_0011 = 8'h22;
	localparam logic [7:0] WAIT_RSV_0100 = 8'h1E;
	localparam logic [7:0] WAIT_RSV_0110 = 8'h3C;
	localparam logic [7:0] WAIT_RSV_0111 = 8'h0C;
	localparam logic [7:0] WAIT_RSV_1100 = 8'h12;
	localparam logic [7:0] WAIT_RSV_1110 = 8'h24;
	localparam logic [7:0] WAIT_RSV_MAX = 8'hAC;
	// wait before reading start-fail flag, reservation disabled
	localparam logic [7:0] WAIT_FAIL_00 = 8'h06;
	localparam logic [7:0] WAIT_FAIL_01 = 8'h06;
	localparam logic [7:0] WAIT_FAIL_10 = 8'h0C;
	localparam logic [7:0] WAIT_FAIL_11 = 8'h03;

	typedef enum logic [1:0] {
		OP_INIT = 2'h0,
		OP_JOIN = 2'h1,
		OP_START = 2'h2,
		OP_STOP = 2'h3
	} i2csr_op_type;

	typedef enum logic [1:0] {
		RES_NONE = 2'h0,
		RES_STARTED = 2'h1,
		RES_RESERVED = 2'h2,
		RES_REJECTED = 2'h3
	} i2csr_res_type;

	typedef struct packed {
		i2csr_op_type op;
		logic clk_ext;
		logic speed;
		logic [1:0] clk_sel;
		logic start_check_enable;
		logic rsv_dis;
		logic [7:0] addr;
	} i2csr_cmd_type;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [2:0] addr;
		logic [7:0] wdata;
	} i2csr_regbus_type;

	typedef enum logic [19:0] {
		ST_IDLE = 20'h0_0001,
		ST_CLR_EN = 20'h0_0002,
		ST_SET_EXT = 20'h0_0004,
		ST_SET_CLK = 20'h0_0008,
		ST_SET_FLG = 20'h0_0010,
		ST_ENABLE = 20'h0_0020,
		ST_SET_STOP = 20'h0_0040,
		ST_WAIT_FREE = 20'h0_0080,
		ST_JOIN_EN = 20'h0_0100,
		ST_JOIN_POLL = 20'h0_0200,
		ST_JOIN_CAP = 20'h0_0400,
		ST_JOIN_REL = 20'h0_0800,
		ST_START_REQ = 20'h0_1000,
		ST_START_WAIT = 20'h0_2000,
		ST_START_RD = 20'h0_4000,
		ST_START_CAP = 20'h0_8000,
		ST_RSV_IRQ = 20'h1_0000,
		ST_LOAD_ADDR = 20'h2_0000,
		ST_STOP_REQ = 20'h4_0000,
		ST_FINISH = 20'h8_0000
	} i2csr_state_type;
endpackage

// file: design/i2csr_host.sv
// host sequencer driving the start/reservation logic of a two-wire bus controller
`timescale 1ns/10ps
`default_nettype none

module i2csr_host
	import i2csr_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_clk_link,
	input wire logic i_cmd_valid,
	input wire i2csr_cmd_type i_cmd,
	output logic o_cmd_ready,
	output logic o_done,
	output i2csr_res_type o_result,
	output i2csr_regbus_type o_reg,
	input wire logic [7:0] i_reg_rdata,
	input wire logic i_bus_irq,
	input wire logic i_scl,
	input wire logic i_sda
);

	// control byte assembly
	function automatic logic [7:0] ctl_byte(input logic en, input logic rel, input logic spie,
		input logic stt, input logic spt);
		logic [7:0] b;
		b = BYTE_ZERO;
		b[CTL_ENABLE_BIT] = en;
		b[CTL_RELEASE_BIT] = rel;
		b[CTL_STOP_IRQ_BIT] = spie;
		b[CTL_START_BIT] = stt;
		b[CTL_STOP_BIT] = spt;
		return b;
	endfunction

	// undocumented settings take the longest wait, safe in every case
	function automatic logic [7:0] rsv_wait(input logic [3:0] sel);
		case (sel)
			4'h0: return WAIT_RSV_0000;
			4'h1: return WAIT_RSV_0001;
			4'h2: return WAIT_RSV_0010;
			4'h3: return WAIT_RSV_0011;
			4'h4: return WAIT_RSV_0100;
			4'h6: return WAIT_RSV_0110;
			4'h7: return WAIT_RSV_0111;
			4'hC: return WAIT_RSV_1100;
			4'hE: return WAIT_RSV_1110;
			default: return WAIT_RSV_MAX;
		endcase
	endfunction

	function automatic logic [7:0] fail_wait(input logic [1:0] sel);
		case (sel)
			2'h0: return WAIT_FAIL_00;
			2'h1: return WAIT_FAIL_01;
			2'h2: return WAIT_FAIL_10;
			default: return WAIT_FAIL_11;
		endcase
	endfunction

	// one write or one read on the device register port
	function automatic i2csr_regbus_type wr_op(input logic [2:0] a, input logic [7:0] d);
		return '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
	endfunction
	function automatic i2csr_regbus_type rd_op(input logic [2:0] a);
		return '{wr: 1'b0, rd: 1'b1, addr: a, wdata: BYTE_ZERO};
	endfunction

	// system domain registers
	i2csr_cmd_type cmd_hold_reg;
	logic req_tgl_reg;
	logic busy_reg;
	logic ack_s1_reg;
	logic ack_s2_reg;
	logic ack_seen_reg;
	// link domain registers
	logic ack_tgl_reg;
	logic req_s1_reg;
	logic req_s2_reg;
	logic req_seen_reg;
	i2csr_res_type res_reg;
	i2csr_res_type res_next;
	i2csr_cmd_type cfg_reg;
	i2csr_state_type state_reg;
	i2csr_state_type state_next;
	i2csr_regbus_type reg_next;
	logic [7:0] wait_cnt_reg;
	logic [7:0] free_cnt_reg;
	logic scl_s1_reg;
	logic scl_s2_reg;
	logic sda_s1_reg;
	logic sda_s2_reg;
	logic en_shadow_reg;

	// handshake decode in both domains
	wire logic ack_edge = ack_s2_reg ^ ack_seen_reg;
	wire logic take_cmd = i_cmd_valid && o_cmd_ready;
	wire logic busy_next = take_cmd ? 1'b1 : (ack_edge ? 1'b0 : busy_reg);
	wire logic new_cmd = req_s2_reg ^ req_seen_reg;
	wire logic bus_high = scl_s2_reg && sda_s2_reg;
	wire logic [7:0] wait_need = cfg_reg.rsv_dis ? fail_wait(cfg_reg.clk_sel)
		: rsv_wait({cfg_reg.clk_ext, cfg_reg.speed, cfg_reg.clk_sel});
	wire logic [7:0] wait_cnt_next = (state_reg == ST_START_WAIT) ? 8'(wait_cnt_reg + 8'h01) : BYTE_ZERO;
	wire logic [7:0] free_cnt_next = (state_reg == ST_WAIT_FREE && bus_high)
		? 8'(free_cnt_reg + 8'h01) : BYTE_ZERO;
	// configuration bytes for init, and the register that tells the start outcome
	wire logic [7:0] ext_byte = 8'(cfg_reg.clk_ext) << CLK_EXT_BIT;
	wire logic [7:0] clk_byte = (8'(cfg_reg.speed) << CLK_SPEED_BIT) | {6'h00, cfg_reg.clk_sel};
	wire logic [7:0] flg_byte = (8'(cfg_reg.start_check_enable) << FLG_START_CHECK_BIT)
		| (8'(cfg_reg.rsv_dis) << FLG_RSV_DISABLE_BIT);
	wire logic [2:0] rd_ofs = cfg_reg.rsv_dis ? OFS_FLAG : OFS_STATUS;

	// system side: the command is held stable until the link toggles back
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			cmd_hold_reg <= '0;
			req_tgl_reg <= 1'b0;
			busy_reg <= 1'b0;
			o_cmd_ready <= 1'b0;
		end
		else
		begin
			busy_reg <= busy_next;
			o_cmd_ready <= !busy_next;
			if (take_cmd)
			begin
				cmd_hold_reg <= i_cmd;
				req_tgl_reg <= !req_tgl_reg;
			end
		end
	end

	// system side: acknowledge toggle crossing and result capture
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			ack_s1_reg <= 1'b0;
			ack_s2_reg <= 1'b0;
			ack_seen_reg <= 1'b0;
			o_done <= 1'b0;
			o_result <= RES_NONE;
		end
		else
		begin
			ack_s1_reg <= ack_tgl_reg;
			ack_s2_reg <= ack_s1_reg;
			ack_seen_reg <= ack_s2_reg;
			o_done <= ack_edge;
			if (ack_edge)
				o_result <= res_reg;
		end
	end

	// link side: request toggle and bus pins pass two flops first
	always_ff @(posedge i_clk_link or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			req_s1_reg <= 1'b0;
			req_s2_reg <= 1'b0;
			req_seen_reg <= 1'b0;
			scl_s1_reg <= 1'b0;
			scl_s2_reg <= 1'b0;
			sda_s1_reg <= 1'b0;
			sda_s2_reg <= 1'b0;
		end
		else
		begin
			req_s1_reg <= req_tgl_reg;
			req_s2_reg <= req_s1_reg;
			req_seen_reg <= req_s2_reg;
			scl_s1_reg <= i_scl;
			scl_s2_reg <= scl_s1_reg;
			sda_s1_reg <= i_sda;
			sda_s2_reg <= sda_s1_reg;
		end
	end

	// link side: sequencer state, counters and registered register port
	always_ff @(posedge i_clk_link or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state_reg <= ST_IDLE;
			cfg_reg <= '0;
			res_reg <= RES_NONE;
			ack_tgl_reg <= 1'b0;
			wait_cnt_reg <= BYTE_ZERO;
			free_cnt_reg <= BYTE_ZERO;
			o_reg <= '0;
			en_shadow_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			res_reg <= res_next;
			wait_cnt_reg <= wait_cnt_next;
			free_cnt_reg <= free_cnt_next;
			o_reg <= reg_next;
			if (state_reg == ST_IDLE && new_cmd)
				cfg_reg <= cmd_hold_reg;
			if (state_reg == ST_FINISH)
				ack_tgl_reg <= !ack_tgl_reg;
			if (reg_next.wr && reg_next.addr == OFS_CONTROL)
				en_shadow_reg <= reg_next.wdata[CTL_ENABLE_BIT];
		end
	end

	// next state and result
	always_comb
	begin
		state_next = state_reg;
		res_next = res_reg;
		case (state_reg)
			ST_IDLE:
				if (new_cmd)
				begin
					res_next = RES_NONE;
					case (cmd_hold_reg.op)
						OP_START: state_next = ST_START_REQ;
						OP_STOP: state_next = ST_STOP_REQ;
						default: state_next = ST_CLR_EN;
					endcase
				end
			// enable cleared before any clock change
			ST_CLR_EN: state_next = (cfg_reg.op == OP_JOIN) ? ST_JOIN_EN : ST_SET_EXT;
			ST_SET_EXT: state_next = ST_SET_CLK;
			ST_SET_CLK: state_next = ST_SET_FLG;
			ST_SET_FLG: state_next = ST_ENABLE;
			// forced busy needs a stop after enabling
			// otherwise confirm a free bus first
			ST_ENABLE: state_next = cfg_reg.start_check_enable ? ST_WAIT_FREE : ST_SET_STOP;
			ST_SET_STOP: state_next = ST_FINISH;
			// both lines high for one frame
			ST_WAIT_FREE:
				if (bus_high && free_cnt_reg == 8'(BUS_FREE_CYC - 8'h01))
					state_next = ST_FINISH;
			ST_JOIN_EN: state_next = ST_JOIN_POLL;
			ST_JOIN_POLL: state_next = ST_JOIN_CAP;
			// release as soon as start is seen
			ST_JOIN_CAP: state_next = i_reg_rdata[STS_START_DET_BIT] ? ST_JOIN_REL : ST_JOIN_POLL;
			ST_JOIN_REL: state_next = ST_FINISH;
			ST_START_REQ: state_next = ST_START_WAIT;
			// wait from the clock-select table before status
			ST_START_WAIT:
				if (wait_cnt_reg == 8'(wait_need - 8'h01))
					state_next = ST_START_RD;
			ST_START_RD: state_next = ST_START_CAP;
			ST_START_CAP:
				if (cfg_reg.rsv_dis)
				begin
					res_next = i_reg_rdata[FLG_START_FAIL_BIT] ? RES_REJECTED : RES_STARTED;
					state_next = i_reg_rdata[FLG_START_FAIL_BIT] ? ST_FINISH : ST_LOAD_ADDR;
				end
				else
				begin
					res_next = i_reg_rdata[STS_MASTER_BIT] ? RES_STARTED : RES_RESERVED;
					state_next = i_reg_rdata[STS_MASTER_BIT] ? ST_LOAD_ADDR : ST_RSV_IRQ;
				end
			// stop interrupt releases the reserved transfer
			ST_RSV_IRQ:
				if (i_bus_irq)
					state_next = ST_LOAD_ADDR;
			ST_LOAD_ADDR: state_next = ST_FINISH;
			ST_STOP_REQ: state_next = ST_FINISH;
			ST_FINISH: state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
	end

	// register port action for each state; start is written once per start command
	always_comb
	begin
		case (state_reg)
			ST_CLR_EN: reg_next = wr_op(OFS_CONTROL, BYTE_ZERO);
			ST_SET_EXT: reg_next = wr_op(OFS_CLK_EXT, ext_byte);
			ST_SET_CLK: reg_next = wr_op(OFS_CLK_SEL, clk_byte);
			ST_SET_FLG: reg_next = wr_op(OFS_FLAG, flg_byte);
			ST_ENABLE: reg_next = wr_op(OFS_CONTROL, ctl_byte(1'b1, 1'b0, 1'b1, 1'b0, 1'b0));
			ST_SET_STOP, ST_STOP_REQ: reg_next = wr_op(OFS_CONTROL, ctl_byte(1'b1, 1'b0, 1'b1, 1'b0, 1'b1));
			ST_JOIN_EN: reg_next = wr_op(OFS_CONTROL, ctl_byte(1'b1, 1'b0, 1'b0, 1'b0, 1'b0));
			ST_JOIN_POLL: reg_next = rd_op(OFS_STATUS);
			ST_JOIN_REL: reg_next = wr_op(OFS_CONTROL, ctl_byte(1'b1, 1'b1, 1'b0, 1'b0, 1'b0));
			// the only start write, once per command
			// stop interrupt stays enabled with the start request
			ST_START_REQ: reg_next = wr_op(OFS_CONTROL, ctl_byte(1'b1, 1'b0, 1'b1, 1'b1, 1'b0));
			ST_START_RD: reg_next = rd_op(rd_ofs);
			ST_LOAD_ADDR: reg_next = wr_op(OFS_SHIFT, cfg_reg.addr);
			default: reg_next = '0;
		endcase
	end

	// status read only after the full table wait
	wait_done_a: assert property (@(posedge i_clk_link) disable iff (!i_rst_n)
		state_reg == ST_START_RD |-> $past(state_reg) == ST_START_WAIT && $past(wait_cnt_reg) == 8'(wait_need - 8'h01))
		else $error("status read before wait elapsed");
	msts_read_a: assert property (@(posedge i_clk_link) disable iff (!i_rst_n)
		state_reg == ST_START_RD && !cfg_reg.rsv_dis |=> o_reg.rd && o_reg.addr == OFS_STATUS)
		else $error("master status not read");
	// rejection check reads the flag register
	fail_read_a: assert property (@(posedge i_clk_link) disable iff (!i_rst_n)
		state_reg == ST_START_RD && cfg_reg.rsv_dis |=> o_reg.rd && o_reg.addr == OFS_FLAG)
		else $error("start-fail flag not read");
	// address written two cycles after the stop interrupt
	rsv_load_a: assert property (@(posedge i_clk_link) disable iff (!i_rst_n)
		state_reg == ST_RSV_IRQ && i_bus_irq |-> ##2 (o_reg.wr && o_reg.addr == OFS_SHIFT))
		else $error("reserved address not loaded");
	// clock select written only while disabled
	clk_order_a: assert property (@(posedge i_clk_link) disable iff (!i_rst_n)
		o_reg.wr && (o_reg.addr == OFS_CLK_SEL || o_reg.addr == OFS_CLK_EXT) |-> !en_shadow_reg)
		else $error("clock changed while enabled");
	// start request carries the stop interrupt enable
	start_spie_a: assert property (@(posedge i_clk_link) disable iff (!i_rst_n)
		o_reg.wr && o_reg.addr == OFS_CONTROL && o_reg.wdata[CTL_START_BIT] |-> o_reg.wdata[CTL_STOP_IRQ_BIT])
		else $error("start without stop interrupt enable");
	// start request never written twice in a row of cycles
	start_once_a: assert property (@(posedge i_clk_link) disable iff (!i_rst_n)
		o_reg.wr && o_reg.wdata[CTL_START_BIT] && o_reg.addr == OFS_CONTROL
		|=> (!(o_reg.wr && o_reg.wdata[CTL_START_BIT]))[*3])
		else $error("start request repeated");
	stop_after_en_a: assert property (@(posedge i_clk_link) disable iff (!i_rst_n)
		$rose(state_reg == ST_SET_STOP) |-> $past(state_reg) == ST_ENABLE ##1 (o_reg.wr && o_reg.wdata[CTL_STOP_BIT]))
		else $error("stop not after enable");
	// init with start check completes only after a full frame of idle lines
	free_wait_a: assert property (@(posedge i_clk_link) disable iff (!i_rst_n)
		state_reg == ST_WAIT_FREE && state_next == ST_FINISH |-> free_cnt_reg == 8'(BUS_FREE_CYC - 8'h01) && bus_high)
		else $error("bus free time too short");
	// joining keeps the stop interrupt off
	join_spie_a: assert property (@(posedge i_clk_link) disable iff (!i_rst_n)
		state_reg == ST_JOIN_EN |=> o_reg.wr && !o_reg.wdata[CTL_STOP_IRQ_BIT] && o_reg.wdata[CTL_ENABLE_BIT])
		else $error("join enabled stop interrupt");
	// done pulse always accompanies renewed readiness
	done_ready_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		o_done |-> o_cmd_ready)
		else $error("done without ready");

endmodule
`default_nettype wire

// file: verification/i2csr_dev_model.sv
// device model: control, status and flag registers with the start and reservation decisions
`timescale 1ns/10ps
`default_nettype none
module i2csr_dev_model
	import i2csr_pkg::*;
(
	input wire logic i_clk_link,
	input wire logic i_rst_n,
	input wire i2csr_regbus_type i_reg,
	input wire logic i_others_busy,
	output logic [7:0] o_rdata,
	output logic o_bus_irq,
	output logic o_scl,
	output logic o_sda,
	output logic [7:0] o_shift,
	output logic o_master,
	output logic o_bsy,
	output logic [7:0] o_conv_cnt
);
	logic [7:0] ctl_reg, flg_reg, clk_reg, ext_reg, rd_mux, noise_reg;
	logic start_det, stop_det, pending, others_q;
	// read mux; outside a read the data changes every cycle so stale values never pass
	always_comb
	begin
		case (i_reg.addr)
			OFS_CONTROL: rd_mux = ctl_reg;
			OFS_STATUS: rd_mux = {o_master, 5'h00, start_det, stop_det};
			OFS_FLAG: rd_mux = {flg_reg[7], o_bsy, 4'h0, flg_reg[1:0]};
			OFS_CLK_SEL: rd_mux = clk_reg;
			OFS_CLK_EXT: rd_mux = ext_reg;
			default: rd_mux = o_shift;
		endcase
	end
	assign o_rdata = i_reg.rd ? rd_mux : noise_reg;
	// others on the bus show low data, high clock
	assign o_sda = ~i_others_busy;
	assign o_scl = 1'b1;
	// register writes and bus events on the falling edge, so the host never
	// samples read data or the interrupt in the step in which they change
	always @(negedge i_clk_link or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			{ctl_reg, flg_reg, clk_reg, ext_reg, o_shift, o_conv_cnt} = '0;
			{start_det, stop_det, pending, others_q, o_master, o_bsy, o_bus_irq} = '0;
			noise_reg = 8'hA5;
		end
		else
		begin
			noise_reg = ~noise_reg;
			o_bus_irq = 1'b0;
			// start by another master opens the reservation window
			if (i_others_busy && !others_q)
			begin
				{start_det, stop_det, o_bsy} = 3'b101;
			end
			// stop turns a pending reservation into a start once
			if (!i_others_busy && others_q)
			begin
				{start_det, stop_det, o_bsy} = 3'b010;
				o_master = o_master | pending;
				o_conv_cnt = o_conv_cnt + {7'h00, pending};
				pending = 1'b0;
				o_bus_irq = ctl_reg[CTL_STOP_IRQ_BIT];
			end
			others_q = i_others_busy;
			if (i_reg.wr)
			begin
				case (i_reg.addr)
					OFS_CONTROL:
					begin
						if (i_reg.wdata[CTL_ENABLE_BIT] && !ctl_reg[CTL_ENABLE_BIT])
						begin
							o_bsy = ~flg_reg[FLG_START_CHECK_BIT];
							start_det = i_others_busy;
						end
						if (i_reg.wdata[CTL_START_BIT])
						begin
							flg_reg[FLG_START_FAIL_BIT] = o_bsy & flg_reg[FLG_RSV_DISABLE_BIT];
							if (!o_bsy)
								o_master = 1'b1;
							else if (!flg_reg[FLG_RSV_DISABLE_BIT] && start_det)
								pending = 1'b1;
						end
						if (i_reg.wdata[CTL_STOP_BIT])
							{o_master, o_bsy} = 2'b00;
						ctl_reg = i_reg.wdata & 8'hFC; // request bits self-clear
					end
					OFS_FLAG: flg_reg[1:0] = i_reg.wdata[1:0];
					OFS_CLK_SEL: clk_reg = i_reg.wdata;
					OFS_CLK_EXT: ext_reg = i_reg.wdata;
					OFS_SHIFT: o_shift = i_reg.wdata;
					default: ;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// file: verification/tb_i2csr_host.sv
// testbench: command-level checks of the start and reservation host against a device model
`timescale 1ns/10ps
`default_nettype none
module tb_i2csr_host
	import i2csr_pkg::*;
;
	logic clk_sys, clk_link, rst_n, cmd_valid, bus_irq, scl, sda, others, master, bsy, cmd_ready, done;
	i2csr_cmd_type cmd;
	i2csr_res_type result;
	i2csr_regbus_type regbus;
	logic [7:0] rdata, shift, conv_cnt;
	logic [31:0] seed;
	int error_cnt, total_checks, gap, cnt, exp_conv;
	bit track;
	int rsv_code[9] = '{0, 1, 2, 3, 4, 6, 7, 12, 14};
	int rsv_n[9] = '{46, 86, 172, 34, 30, 60, 12, 18, 36};
	int fail_n[4] = '{6, 6, 12, 3};
	realtime t0;
	// clocks: link offset by a fraction so its edges never meet the drive points
	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	initial
	begin
		clk_link = 1'b0;
		#37.3;
		forever #62.5 clk_link = ~clk_link;
	end
	i2csr_host dut_u (
		.i_clk_sys(clk_sys),
		.i_rst_n(rst_n),
		.i_clk_link(clk_link),
		.i_cmd_valid(cmd_valid),
		.i_cmd(cmd),
		.o_cmd_ready(cmd_ready),
		.o_done(done),
		.o_result(result),
		.o_reg(regbus),
		.i_reg_rdata(rdata),
		.i_bus_irq(bus_irq),
		.i_scl(scl),
		.i_sda(sda)
	);
	i2csr_dev_model dev_u (
		.i_clk_link(clk_link),
		.i_rst_n(rst_n),
		.i_reg(regbus),
		.i_others_busy(others),
		.o_rdata(rdata),
		.o_bus_irq(bus_irq),
		.o_scl(scl),
		.o_sda(sda),
		.o_shift(shift),
		.o_master(master),
		.o_bsy(bsy),
		.o_conv_cnt(conv_cnt)
	);
	// link cycles from the start-request write to the following read
	always @(posedge clk_link)
	begin
		if (regbus.wr && regbus.addr == OFS_CONTROL && regbus.wdata == 8'h92)
		begin
			cnt = 0;
			track = 1'b1;
		end
		else
		begin
			cnt = cnt + 1;
			if (regbus.rd && track)
			begin
				gap = cnt;
				track = 1'b0;
			end
		end
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic i2csr_cmd_type mk(input i2csr_op_type op, input logic [3:0] code, input logic stc,
		input logic rsvd);
		return i2csr_cmd_type'({op, code, stc, rsvd, seed[7:0]});
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		total_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("FAIL t=%0t %s: seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic hang(input string what);
		check(32'h0, 32'h1, what);
		finish_test();
	endtask
	// one command: hold it until taken, then wait for the done pulse
	task automatic run_cmd(input i2csr_cmd_type c);
		int k;
		cmd = c;
		cmd_valid = 1'b1;
		for (k = 0; cmd_ready !== 1'b1; k++)
		begin
			if (k > 100)
				hang("command never taken");
			@(posedge clk_sys);
			#1;
		end
		@(posedge clk_sys);
		#1;
		cmd_valid = 1'b0;
		seed = lfsr(seed);
		for (k = 0; done !== 1'b1; k++)
		begin
			if (k > 40000)
				hang("command never done");
			@(posedge clk_sys);
			#1;
		end
	endtask
	// init, bus state, then a start; a reserved start gets its bus release later
	task automatic start_chk(input logic [3:0] code, input logic rsvd, input logic busy, input int n);
		i2csr_res_type exp;
		run_cmd(mk(OP_INIT, code, 1'b0, rsvd));
		others = busy;
		repeat (4) @(posedge clk_link);
		@(posedge clk_sys);
		#1;
		gap = -1;
		exp = !busy ? RES_STARTED : (rsvd ? RES_REJECTED : RES_RESERVED);
		exp_conv = exp_conv + ((exp == RES_RESERVED) ? 1 : 0);
		fork
			run_cmd(mk(OP_START, code, 1'b0, rsvd));
			if (exp == RES_RESERVED)
			begin
				repeat (300) @(posedge clk_link);
				#3 others = 1'b0;
			end
		join
		check(result, exp, "start outcome");
		check(gap, n + 1, "wait before status read");
		if (exp != RES_REJECTED)
			check(shift, cmd.addr, "address load");
		check(conv_cnt, exp_conv, "reservation conversions");
		others = 1'b0;
	endtask
	// main sequence
	initial
	begin
		{rst_n, cmd_valid, others, track} = '0;
		cmd = '0;
		seed = 32'h17d3_f63e;
		repeat (10) @(posedge clk_link);
		@(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		t0 = $realtime;
		run_cmd(mk(OP_INIT, 4'h0, 1'b1, 1'b0));
		check(result, RES_NONE, "init result");
		check(bsy, 1'b0, "busy flag after checked enable");
		check(($realtime - t0) >= 10000.0, 1'b1, "bus free one frame");
		others = 1'b1;
		run_cmd(mk(OP_JOIN, 4'h0, 1'b0, 1'b0));
		check(result, RES_NONE, "join result");
		check(dev_u.ctl_reg, 8'hC0, "release with stop irq off");
		others = 1'b0;
		for (int i = 0; i < 9; i++)
			start_chk(rsv_code[i][3:0], 1'b0, 1'b0, rsv_n[i]);
		start_chk(4'h5, 1'b0, 1'b0, 172);
		for (int i = 0; i < 4; i++)
		begin
			start_chk({2'b00, i[1:0]}, 1'b1, 1'b1, fail_n[i]);
			start_chk({2'b00, i[1:0]}, 1'b1, 1'b0, fail_n[i]);
		end
		start_chk(4'h3, 1'b0, 1'b1, 34);
		check(master, 1'b1, "master after reserved start");
		others = 1'b1;
		repeat (8) @(posedge clk_link);
		#3 others = 1'b0;
		repeat (8) @(posedge clk_link);
		@(posedge clk_sys);
		#1;
		check(conv_cnt, exp_conv, "second stop converts nothing");
		run_cmd(mk(OP_STOP, 4'h0, 1'b0, 1'b0));
		check(result, RES_NONE, "stop result");
		check(master, 1'b0, "master after stop");
		finish_test();
	end
endmodule
`default_nettype wire
